// *** design/buio_panel.sv ***
// Notes on behaviour
// RQ1: buttons read high released, low pressed
// RQ2: buttons pre-debounced, usable as clock/reset
// RQ3: switches undebounced, level data only
// RQ4: switch down gives low, up high
// RQ5: LED high lights, low darkens, independent
// RQ6: segment low lights, high blanks
// RQ7: six digits in pairs, bits 0..6
// RQ8: cold reset clears processor, PHY, USB
// RQ9: warm reset clears system domains, not debug
// RQ10: four 50 MHz fabric reference clocks
// RQ11: 25 MHz to processor and to PHY
// RQ12: user decodes nibbles, syncs switches
`include "buio_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module buio_panel #(
  parameter int NUM_KEYS     = `BUIO_NUM_KEYS,
  parameter int NUM_SWITCHES = `BUIO_NUM_SWITCHES,
  parameter int NUM_LEDS     = `BUIO_NUM_LEDS
) (
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  // board side
  input  wire logic [NUM_KEYS-1:0]     key_pad_n,
  input  wire logic [NUM_SWITCHES-1:0] slide_switch_pad,
  input  wire logic                    proc_cold_btn_n,
  input  wire logic                    proc_warm_btn_n,
  input  wire logic                    fabric_ref_clk_a,
  input  wire logic                    fabric_ref_clk_b,
  input  wire logic                    fabric_ref_clk_c,
  input  wire logic                    fabric_ref_clk_d,
  input  wire logic                    ref_clk_25_proc,
  input  wire logic                    ref_clk_25_phy,
  // user-logic side
  input  wire logic [NUM_LEDS-1:0]     led_req,
  input  wire buio_pkg::buio_seg_t     seg_req0,
  input  wire buio_pkg::buio_seg_t     seg_req1,
  input  wire buio_pkg::buio_seg_t     seg_req2,
  input  wire buio_pkg::buio_seg_t     seg_req3,
  input  wire buio_pkg::buio_seg_t     seg_req4,
  input  wire buio_pkg::buio_seg_t     seg_req5,
  output logic [NUM_KEYS-1:0]          key_in_n,
  output logic [NUM_SWITCHES-1:0]      slide_switch_in,
  output logic [NUM_LEDS-1:0]          red_led_out,
  output buio_pkg::buio_seg_t          seg_digit0,
  output buio_pkg::buio_seg_t          seg_digit1,
  output buio_pkg::buio_seg_t          seg_digit2,
  output buio_pkg::buio_seg_t          seg_digit3,
  output buio_pkg::buio_seg_t          seg_digit4,
  output buio_pkg::buio_seg_t          seg_digit5,
  output logic                         proc_cold_reset_n,
  output logic                         proc_warm_reset_n,
  output logic                         phy_reset_n,
  output logic                         usb_reset_n,
  output logic                         debug_reset_n,
  output logic [`BUIO_NUM_FAB_CLKS-1:0] fabric_clk_out,
  output logic                         proc_ref_clk_a,
  output logic                         proc_ref_clk_b
);
  import buio_pkg::*;

  // button request, decoded fresh each cycle; no memory needed
  buio_proc_state_t btn_state;
  logic [4:0]       fan_n;

  // reset fan-out per request, bits {cold, warm, phy, usb, debug}, low holds in reset
  function automatic logic [4:0] fanout_n(input buio_proc_state_t st);
    logic [4:0] lines;
    lines = `BUIO_FAN_RUN;
    case (st)
      BUIO_PROC_COLD: begin
        lines = `BUIO_FAN_COLD; // RQ8
      end
      BUIO_PROC_WARM: begin
        lines = `BUIO_FAN_WARM; // RQ9
      end
      default: begin
        lines = `BUIO_FAN_RUN;
      end
    endcase
    return lines;
  endfunction

  // while the fabric is in reset every downstream line is held, as for a cold reset
  localparam logic [4:0] FAN_RST_N = `BUIO_FAN_COLD;

  // clocks are routed straight through; registering would halve them
  assign fabric_clk_out = {fabric_ref_clk_d, fabric_ref_clk_c,
                           fabric_ref_clk_b, fabric_ref_clk_a}; // RQ10
  assign proc_ref_clk_a = ref_clk_25_proc; // RQ11
  assign proc_ref_clk_b = ref_clk_25_phy;  // RQ11

  // buttons pass as-is, already clean in hardware, released reads high
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      key_in_n <= NUM_KEYS'(`BUIO_KEY_RELEASED); // RQ1
    end else begin
      key_in_n <= key_pad_n; // RQ1 RQ2
    end
  end

  // switches: raw level, no filtering, down is low
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      slide_switch_in <= NUM_SWITCHES'(`BUIO_SW_RST);
    end else begin
      slide_switch_in <= slide_switch_pad; // RQ3 RQ4
    end
  end

  // leds active high, one pin each
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      red_led_out <= NUM_LEDS'(`BUIO_LED_RST);
    end else begin
      red_led_out <= led_req; // RQ5
    end
  end

  // digit 0, low pair; segments active low, blank in reset so nothing flashes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      seg_digit0 <= `BUIO_SEG_BLANK; // RQ6
    end else begin
      seg_digit0 <= seg_req0; // RQ7
    end
  end

  // digit 1, low pair
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      seg_digit1 <= `BUIO_SEG_BLANK; // RQ6
    end else begin
      seg_digit1 <= seg_req1; // RQ7
    end
  end

  // digit 2, middle pair
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      seg_digit2 <= `BUIO_SEG_BLANK; // RQ6
    end else begin
      seg_digit2 <= seg_req2; // RQ7
    end
  end

  // digit 3, middle pair
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      seg_digit3 <= `BUIO_SEG_BLANK; // RQ6
    end else begin
      seg_digit3 <= seg_req3; // RQ7
    end
  end

  // digit 4, high pair
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      seg_digit4 <= `BUIO_SEG_BLANK; // RQ6
    end else begin
      seg_digit4 <= seg_req4; // RQ7
    end
  end

  // digit 5, high pair; pairing is physical only, each digit is independent
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      seg_digit5 <= `BUIO_SEG_BLANK; // RQ6
    end else begin
      seg_digit5 <= seg_req5; // RQ7
    end
  end

  // cold wins over warm; request follows the buttons each cycle
  always_comb begin
    if (!proc_cold_btn_n) begin
      btn_state = BUIO_PROC_COLD; // RQ8
    end else if (!proc_warm_btn_n) begin
      btn_state = BUIO_PROC_WARM; // RQ9
    end else begin
      btn_state = BUIO_PROC_RUN;
    end
  end

  // one decode feeds all five lines so they can never disagree
  assign fan_n = fanout_n(btn_state);

  // processor cold reset line
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      proc_cold_reset_n <= FAN_RST_N[4];
    end else begin
      proc_cold_reset_n <= fan_n[4]; // RQ8
    end
  end

  // processor system domains, low on either button
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      proc_warm_reset_n <= FAN_RST_N[3];
    end else begin
      proc_warm_reset_n <= fan_n[3]; // RQ8 RQ9
    end
  end

  // network transceiver, cold reset only
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phy_reset_n <= FAN_RST_N[2];
    end else begin
      phy_reset_n <= fan_n[2]; // RQ8
    end
  end

  // usb host, cold reset only
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      usb_reset_n <= FAN_RST_N[1];
    end else begin
      usb_reset_n <= fan_n[1]; // RQ8
    end
  end

  // debug stays up on warm reset so an attached debugger keeps its hold
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      debug_reset_n <= FAN_RST_N[0];
    end else begin
      debug_reset_n <= fan_n[0]; // RQ9
    end
  end
endmodule
`default_nettype wire

// *** design/buio_defs.svh ***
`ifndef BUIO_DEFS_SVH
`define BUIO_DEFS_SVH
// panel population
`define BUIO_NUM_KEYS      4
`define BUIO_NUM_SWITCHES  10
`define BUIO_NUM_LEDS      10
`define BUIO_NUM_DIGITS    6
`define BUIO_SEG_BITS      7
`define BUIO_NUM_FAB_CLKS  4
// reset values
`define BUIO_LED_RST       10'h000
`define BUIO_SEG_BLANK     7'h7F
`define BUIO_KEY_RELEASED  4'hF
`define BUIO_SW_RST        10'h000
// reset fan-out codes, active low, bits {cold, warm, phy, usb, debug}
`define BUIO_FAN_COLD      5'h00
`define BUIO_FAN_WARM      5'h17
`define BUIO_FAN_RUN       5'h1F
// clock rates in MHz
`define BUIO_FAB_CLK_MHZ   50
`define BUIO_PROC_CLK_MHZ  25
`define BUIO_SYS_CLK_MHZ   50
`endif

// *** design/buio_pkg.sv ***
`include "buio_defs.svh"
package buio_pkg;
  typedef logic [`BUIO_SEG_BITS-1:0]    buio_seg_t;
  typedef logic [`BUIO_NUM_LEDS-1:0]    buio_led_t;
  typedef logic [`BUIO_NUM_SWITCHES-1:0] buio_sw_t;
  typedef logic [`BUIO_NUM_KEYS-1:0]    buio_key_t;
  // processor reset state
  typedef enum logic [1:0] {
    BUIO_PROC_RUN,
    BUIO_PROC_WARM,
    BUIO_PROC_COLD
  } buio_proc_state_t;
endpackage

// *** tb/buio_panel_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module buio_panel_asserts
  import buio_pkg::*;
(
  input wire logic      sys_clk,
  input wire logic      reset,
  input wire buio_key_t key_pad_n,
  input wire buio_sw_t  slide_switch_pad,
  input wire logic      proc_cold_btn_n,
  input wire logic      proc_warm_btn_n,
  input wire logic      fabric_ref_clk_a,
  input wire logic      ref_clk_25_proc,
  input wire buio_led_t led_req,
  input wire buio_seg_t seg_req0,
  input wire buio_key_t key_in_n,
  input wire buio_sw_t  slide_switch_in,
  input wire buio_led_t red_led_out,
  input wire buio_seg_t seg_digit0,
  input wire logic      proc_cold_reset_n,
  input wire logic      proc_warm_reset_n,
  input wire logic      phy_reset_n,
  input wire logic      usb_reset_n,
  input wire logic      debug_reset_n,
  input wire logic [3:0] fabric_clk_out,
  input wire logic      proc_ref_clk_a
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  a_key_level: assert property (!$past(reset) |-> key_in_n == $past(key_pad_n))
    else $error("button copy wrong");
  a_switch_level: assert property (!$past(reset) |-> slide_switch_in == $past(slide_switch_pad))
    else $error("switch copy wrong");
  a_led_drive: assert property (led_req != $past(led_req) |=> red_led_out == $past(led_req))
    else $error("led drive wrong");
  a_seg_drive: assert property (!$past(reset) |-> seg_digit0 == $past(seg_req0))
    else $error("segment drive wrong");
  a_reset_blank: assert property ($past(reset) |-> key_in_n == 4'hF && seg_digit0 == 7'h7F && red_led_out == 10'h000
    && !(proc_cold_reset_n | proc_warm_reset_n | phy_reset_n | usb_reset_n | debug_reset_n))
    else $error("reset values wrong");
  a_cold_all: assert property (!proc_cold_btn_n |=> !(proc_cold_reset_n | proc_warm_reset_n | phy_reset_n | usb_reset_n | debug_reset_n))
    else $error("cold reset fan-out wrong");
  a_warm_debug: assert property (proc_cold_btn_n && !proc_warm_btn_n |=> !proc_warm_reset_n && proc_cold_reset_n
    && debug_reset_n && phy_reset_n && usb_reset_n)
    else $error("warm reset scope wrong");
  a_run_release: assert property (proc_cold_btn_n && proc_warm_btn_n |=>
    (proc_cold_reset_n & proc_warm_reset_n & phy_reset_n & usb_reset_n & debug_reset_n))
    else $error("reset release wrong");
  a_clk_pass: assert property (fabric_clk_out[0] == fabric_ref_clk_a && proc_ref_clk_a == ref_clk_25_proc)
    else $error("clock pass-through wrong");
  c_cold: cover property (!proc_cold_btn_n);
  c_warm: cover property (!proc_warm_btn_n);
  c_led: cover property (red_led_out != 10'h000);
endmodule
`default_nettype wire

// *** tb/buio_user_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module buio_user_model
  import buio_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire buio_sw_t   slide_switch_in,
  input  wire logic [3:0] nibble,
  output buio_led_t       led_req,
  output buio_seg_t       seg_req0,
  output buio_seg_t       seg_req1,
  output buio_seg_t       seg_req2,
  output buio_seg_t       seg_req3,
  output buio_seg_t       seg_req4,
  output buio_seg_t       seg_req5
);
  // nibble to active-low segments, bit 0 is segment 0
  localparam buio_seg_t DEC [16] = '{7'h40, 7'h79, 7'h24, 7'h30, 7'h19, 7'h12, 7'h02, 7'h78,
                                     7'h00, 7'h10, 7'h08, 7'h03, 7'h46, 7'h21, 7'h06, 7'h0E};
  buio_sw_t sync_ff;
  // each digit shows nibble plus its index, so digits are told apart
  assign seg_req0 = DEC[nibble];
  assign seg_req1 = DEC[nibble + 4'h1];
  assign seg_req2 = DEC[nibble + 4'h2];
  assign seg_req3 = DEC[nibble + 4'h3];
  assign seg_req4 = DEC[nibble + 4'h4];
  assign seg_req5 = DEC[nibble + 4'h5];
  // switches bounce, so two flops before they light the leds
  always_ff @(posedge sys_clk) begin
    sync_ff <= slide_switch_in;
    led_req <= sync_ff;
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import buio_pkg::*;
  logic      sys_clk, reset, proc_cold_btn_n, proc_warm_btn_n, ref_clk_25_proc, ref_clk_25_phy;
  logic      fabric_ref_clk_a, fabric_ref_clk_b, fabric_ref_clk_c, fabric_ref_clk_d, proc_ref_clk_a, proc_ref_clk_b;
  logic      proc_cold_reset_n, proc_warm_reset_n, phy_reset_n, usb_reset_n, debug_reset_n;
  logic [3:0] nibble, fabric_clk_out;
  buio_key_t key_pad_n, key_in_n;
  buio_sw_t  slide_switch_pad, slide_switch_in;
  buio_led_t led_req, red_led_out;
  buio_seg_t seg_req0, seg_req1, seg_req2, seg_req3, seg_req4, seg_req5;
  buio_seg_t seg_digit0, seg_digit1, seg_digit2, seg_digit3, seg_digit4, seg_digit5;
  int        mismatches = 0;
  int        comparisons = 0;
  buio_panel buio_panel_i (.*);
  buio_user_model buio_user_model_i (.*);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_keys;
    for (int i = 0; i < 4; i++) begin
      key_pad_n = ~(4'h1 << i);
      step(1);
      chk(key_in_n, key_pad_n);
    end
  endtask
  task automatic t_switch_led;
    // two-flop sync in user logic adds two cycles before the led edge
    for (int i = 0; i < 2; i++) begin
      slide_switch_pad = i ? 10'h15A : 10'h2A5;
      step(1);
      chk(slide_switch_in, slide_switch_pad);
      step(3);
      chk(red_led_out, slide_switch_pad);
    end
  endtask
  task automatic t_segments;
    nibble = 4'h0;
    step(1);
    chk(seg_digit0, 7'h40);
    chk(seg_digit5, 7'h12);
    chk(seg_digit1, 7'h79);
    chk(seg_digit2, 7'h24);
    chk(seg_digit3, 7'h30);
    nibble = 4'h8;
    step(1);
    chk(seg_digit0, 7'h00);
    chk(seg_digit4, 7'h46);
    chk(seg_digit1, 7'h10);
    chk(seg_digit2, 7'h08);
    chk(seg_digit3, 7'h03);
    chk(seg_digit5, 7'h21);
  endtask
  task automatic t_resets;
    proc_warm_btn_n = 1'b0;
    step(1);
    chk({proc_cold_reset_n, proc_warm_reset_n, phy_reset_n, usb_reset_n, debug_reset_n}, 5'h17);
    proc_cold_btn_n = 1'b0;
    step(1);
    chk({proc_cold_reset_n, proc_warm_reset_n, phy_reset_n, usb_reset_n, debug_reset_n}, 5'h00);
    {proc_cold_btn_n, proc_warm_btn_n} = 2'h3;
    step(1);
    chk({proc_cold_reset_n, proc_warm_reset_n, phy_reset_n, usb_reset_n, debug_reset_n}, 5'h1F);
  endtask
  task automatic t_clocks;
    for (int i = 0; i < 2; i++) begin
      {fabric_ref_clk_d, fabric_ref_clk_c, fabric_ref_clk_b, fabric_ref_clk_a, ref_clk_25_phy, ref_clk_25_proc} = i ? 6'h1A : 6'h25;
      step(1);
      chk({fabric_clk_out, proc_ref_clk_b, proc_ref_clk_a}, i ? 6'h1A : 6'h25);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // hang guard, about eight times the expected run
  initial begin
    #4000;
    mismatches++;
    complete_run;
  end
  initial begin
    {reset, proc_cold_btn_n, proc_warm_btn_n, key_pad_n, slide_switch_pad, nibble} = {3'h7, 4'hF, 10'h000, 4'h0};
    {fabric_ref_clk_d, fabric_ref_clk_c, fabric_ref_clk_b, fabric_ref_clk_a, ref_clk_25_phy, ref_clk_25_proc} = 6'h00;
    step(6);
    chk(seg_digit3, 7'h7F);
    chk(key_in_n, 4'hF);
    chk(red_led_out, 10'h000);
    chk(slide_switch_in, 10'h000);
    chk({proc_cold_reset_n, proc_warm_reset_n, phy_reset_n, usb_reset_n, debug_reset_n}, 5'h00);
    reset = 1'b0;
    t_keys;
    t_switch_led;
    t_segments;
    t_resets;
    t_clocks;
    complete_run;
  end
endmodule
bind buio_panel buio_panel_asserts buio_panel_asserts_i (.*);
`default_nettype wire
